// ===== pkg/btac_consts.vh
// constants of the bus trace acquisition control block
`ifndef BTAC_CONSTS_VH
`define BTAC_CONSTS_VH
`define BTAC_DEPTH 16
`define BTAC_AW 4
`define BTAC_CLK_PS 10000
`define BTAC_TS_125NS_PS 125000
`define BTAC_TS_250NS_PS 250000
`define BTAC_TS_500NS_PS 500000
`define BTAC_TS_1US_PS 1000000
`define BTAC_TS_2US_PS 2000000
`define BTAC_TS_4US_PS 4000000
`define BTAC_TS_8US_PS 8000000
`define BTAC_TS_16US_PS 16000000
`define BTAC_TS_100US_PS 100000000
`define BTAC_RES_OFF 4'h0
`define BTAC_CYC_DMAC 0
`define BTAC_CYC_XFER 1
`define BTAC_CYC_REFRESH 2
`define BTAC_REC_W 63
`define BTAC_DELAY_W 16
`endif

// ===== hdl/btac_buffer2.v
// two-entry valid/ready buffer for trace records
`timescale 1ns/1ps
module btac_buffer2 #(
    parameter W = 58
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire inValid,
    output wire inReady,
    input wire [W-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [W-1:0] outData
);
    reg [W-1:0] mem_q [0:1];
    reg rdPtr_q;
    reg wrPtr_q;
    reg [1:0] count_q;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    assign inReady = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData = mem_q[rdPtr_q];
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end
endmodule // btac_buffer2

// ===== hdl/btac_trace_ctrl.v
// trace capture control with circular store and time stamp
`timescale 1ns/1ps
`include "btac_consts.vh"
module btac_trace_ctrl (
    input wire ref_clk,
    input wire sys_rst,
    input wire progStart,
    input wire busValid,
    input wire [23:0] busAddr,
    input wire [15:0] busData,
    input wire busWrite,
    input wire [2:0] busArea,
    input wire [2:0] busStatus,
    input wire [2:0] busClocks,
    input wire [3:0] probes,
    input wire nmiLevel,
    input wire [7:0] irqLevels,
    input wire [2:0] cycleKind,
    input wire [15:0] eventMatch,
    input wire [15:0] eventDefined,
    input wire [2:0] suppressMask,
    input wire [3:0] tsResolution,
    input wire freeMode,
    input wire [15:0] startSel,
    input wire [15:0] haltSel,
    input wire stopEnable,
    input wire [15:0] stopSel,
    input wire delayEnable,
    input wire [15:0] delaySel,
    input wire [15:0] delayCount,
    input wire [63:0] rangeStartSel,
    input wire [63:0] rangeEndSel,
    input wire [3:0] rangeEnable,
    input wire [3:0] readIndex,
    output reg [62:0] readRecord,
    output wire capturing,
    output wire stopped,
    output wire [3:0] newestIndex,
    output wire [3:0] stopIndex,
    output wire bufferWrapped,
    output wire [31:0] timeStamp,
    output wire busReady
);
    localparam S_IDLE = 2'h0;
    localparam S_RUN = 2'h1;
    localparam S_DELAY = 2'h2;
    localparam S_STOP = 2'h3;
    // tick periods in ps; a phase accumulator keeps 125 ns exact on average
    localparam [31:0] CLKPS = `BTAC_CLK_PS;
    localparam [31:0] N125 = `BTAC_TS_125NS_PS;
    localparam [31:0] N250 = `BTAC_TS_250NS_PS;
    localparam [31:0] N500 = `BTAC_TS_500NS_PS;
    localparam [31:0] N1U = `BTAC_TS_1US_PS;
    localparam [31:0] N2U = `BTAC_TS_2US_PS;
    localparam [31:0] N4U = `BTAC_TS_4US_PS;
    localparam [31:0] N8U = `BTAC_TS_8US_PS;
    localparam [31:0] N16U = `BTAC_TS_16US_PS;
    localparam [31:0] N100U = `BTAC_TS_100US_PS;

    reg [1:0] state_q;
    reg [31:0] tickCnt_q;
    reg [31:0] stamp_q;
    reg [`BTAC_AW-1:0] wrPtr_q;
    reg wrapped_q;
    reg [`BTAC_AW-1:0] stopPtr_q;
    reg [15:0] delayLeft_q;
    reg [3:0] inRange_q;
    reg [62:0] store_q [0:`BTAC_DEPTH-1];
    reg [31:0] tickLimit;
    wire tsOn = (tsResolution != `BTAC_RES_OFF);

    // tick divider for the chosen resolution
    always @* begin
        case (tsResolution)
            4'h1: tickLimit = N125;
            4'h2: tickLimit = N250;
            4'h3: tickLimit = N500;
            4'h4: tickLimit = N1U;
            4'h5: tickLimit = N2U;
            4'h6: tickLimit = N4U;
            4'h7: tickLimit = N8U;
            4'h8: tickLimit = N16U;
            4'h9: tickLimit = N100U;
            default: tickLimit = 32'h0;
        endcase
    end
    wire [31:0] accNext = tickCnt_q + CLKPS;
    wire tick = tsOn && (tickLimit != 32'h0) && (accNext >= tickLimit);

    always @(posedge ref_clk) begin
        if (sys_rst || progStart || !tsOn) begin
            tickCnt_q <= 32'h0;
            stamp_q <= 32'h0;
        end else if (tick) begin
            tickCnt_q <= accNext - tickLimit;
            stamp_q <= stamp_q + 32'h1;
        end else begin
            tickCnt_q <= accNext;
        end
    end
    assign timeStamp = stamp_q;

    // event qualification; undefined points never match, and a stop or delay selection naming one is disabled
    wire [15:0] liveMatch = eventMatch & eventDefined;
    wire startHit = |(liveMatch & startSel);
    wire haltHit = |(liveMatch & haltSel);
    wire stopHit = stopEnable &&
        |(liveMatch & stopSel) && ((stopSel & ~eventDefined) == 16'h0);
    wire delayHit = delayEnable &&
        |(liveMatch & delaySel) && ((delaySel & ~eventDefined) == 16'h0);

    // range windows, one per generate entry
    wire [3:0] rangeOpen;
    wire [3:0] rangeUse;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gRange
            wire [15:0] sSel = rangeStartSel[g*16 +: 16];
            wire [15:0] eSel = rangeEndSel[g*16 +: 16];
            wire usable = rangeEnable[g] && !freeMode &&
                ((sSel & ~eventDefined) == 16'h0) &&
                ((eSel & ~eventDefined) == 16'h0) && (sSel != 16'h0);
            wire sHit = |(liveMatch & sSel);
            wire eHit = |(liveMatch & eSel);
            always @(posedge ref_clk) begin
                if (sys_rst || progStart || !usable) begin
                    inRange_q[g] <= 1'b0;
                end else if (sHit) begin
                    inRange_q[g] <= 1'b1;
                end else if (eHit) begin
                    inRange_q[g] <= 1'b0;
                end
            end
            assign rangeOpen[g] = usable && (inRange_q[g] || sHit);
            assign rangeUse[g] = usable;
        end
    endgenerate
    wire anyRange = |rangeUse;
    wire rangeOk = !anyRange || (|rangeOpen);

    wire suppressed = |(suppressMask & cycleKind);
    wire active = (state_q == S_RUN) || (state_q == S_DELAY);
    wire recordNow = busValid && active && !suppressed && rangeOk;

    // record layout: stamp mode keeps address, data, direction and stamp
    wire [62:0] fullRec = {busAddr, busData, busWrite, busArea, busStatus,
        busClocks, probes, nmiLevel, irqLevels};
    wire [62:0] stampRec = {5'h00, busAddr, busData, busWrite, 1'b1,
        stamp_q[15:0]};
    wire [62:0] newRec = tsOn ? stampRec : fullRec;
    // marks the record at which a halt, stop or delay event matched in the run state
    wire markNow = (state_q == S_RUN) && (haltHit || stopHit || delayHit);

    wire bufOutValid;
    wire [63:0] bufOutData;
    btac_buffer2 #(
        .W(`BTAC_REC_W + 1)
    ) uBuf (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst || progStart),
        .inValid(recordNow),
        .inReady(busReady),
        .inData({markNow, newRec}),
        .outValid(bufOutValid),
        .outReady(1'b1),
        .outData(bufOutData)
    );

    // capture sequencing
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            delayLeft_q <= 16'h0;
        end else if (progStart) begin
            state_q <= freeMode ? S_RUN : S_IDLE;
            delayLeft_q <= 16'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (startHit) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (haltHit || stopHit) begin
                        state_q <= S_STOP;
                    end else if (delayHit) begin
                        delayLeft_q <= delayCount;
                        state_q <= (delayCount == 16'h0) ? S_STOP : S_DELAY;
                    end
                end
                S_DELAY: begin
                    if (haltHit || stopHit) begin
                        state_q <= S_STOP;
                    end else if (busValid && delayLeft_q != 16'h0) begin
                        delayLeft_q <= delayLeft_q - 16'h1;
                        if (delayLeft_q == 16'h1) begin
                            state_q <= S_STOP;
                        end
                    end
                end
                S_STOP: begin
                    state_q <= S_STOP;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // circular store with wrapping write pointer
    always @(posedge ref_clk) begin
        if (sys_rst || progStart) begin
            wrPtr_q <= {`BTAC_AW{1'b0}};
            wrapped_q <= 1'b0;
            stopPtr_q <= {`BTAC_AW{1'b0}};
        end else if (bufOutValid) begin
            if (bufOutData[`BTAC_REC_W]) begin
                stopPtr_q <= wrPtr_q;
            end
            wrPtr_q <= wrPtr_q + {{(`BTAC_AW-1){1'b0}}, 1'b1};
            if (wrPtr_q == {`BTAC_AW{1'b1}}) begin
                wrapped_q <= 1'b1;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (bufOutValid) begin
            store_q[wrPtr_q] <= bufOutData[`BTAC_REC_W-1:0];
        end
    end
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            readRecord <= 63'h0;
        end else begin
            readRecord <= store_q[readIndex];
        end
    end

    assign newestIndex = wrPtr_q - {{(`BTAC_AW-1){1'b0}}, 1'b1};
    assign stopIndex = stopPtr_q;
    assign bufferWrapped = wrapped_q;
    assign capturing = active;
    assign stopped = (state_q == S_STOP);
endmodule // btac_trace_ctrl

// ===== dv/btac_trace_ctrl_chk.sv
// assertions on the trace capture control ports
`timescale 1ns/1ps
module btac_trace_ctrl_chk (
    input wire ref_clk,
    input wire sys_rst,
    input wire progStart,
    input wire freeMode,
    input wire [15:0] eventMatch,
    input wire [15:0] eventDefined,
    input wire [15:0] startSel,
    input wire [15:0] haltSel,
    input wire stopEnable,
    input wire [15:0] stopSel,
    input wire capturing,
    input wire stopped,
    input wire [3:0] newestIndex,
    input wire bufferWrapped,
    input wire [31:0] timeStamp
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire [15:0] hit = eventMatch & eventDefined;
    property p_free_start;
        progStart && freeMode |=> capturing;
    endproperty
    a_free_start: assert property (p_free_start)
        else $error("free mode did not start capture");
    property p_no_start;
        progStart && !freeMode && !(|(hit & startSel)) |=> !capturing;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("capture began without start event");
    property p_halt;
        capturing && !progStart && |(hit & haltSel) |=> stopped;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt event did not stop capture");
    property p_stop_now;
        capturing && !progStart && stopEnable && |(hit & stopSel) |=> stopped;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("immediate stop ignored");
    property p_stop_hold;
        stopped && !progStart |=> stopped && !capturing;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped state left without program start");
    property p_stamp_clr;
        progStart |=> timeStamp == 32'h0;
    endproperty
    a_stamp_clr: assert property (p_stamp_clr)
        else $error("stamp not cleared at program start");
    property p_stamp_step;
        !progStart |=> timeStamp == $past(timeStamp)
            || timeStamp == $past(timeStamp) + 32'h1;
    endproperty
    a_stamp_step: assert property (p_stamp_step)
        else $error("stamp moved by more than one");
    property p_ptr_step;
        !progStart |=> newestIndex == $past(newestIndex)
            || newestIndex == $past(newestIndex) + 4'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("write pointer skipped");
    property p_wrap;
        $rose(bufferWrapped) |-> newestIndex == 4'hF;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap flag without pointer wrap");
    c_wrap: cover property ($rose(bufferWrapped));
    c_halt: cover property ($rose(stopped));
    c_free: cover property (progStart && freeMode);
endmodule // btac_trace_ctrl_chk
bind btac_trace_ctrl btac_trace_ctrl_chk btac_trace_ctrl_chk_inst (
    .ref_clk, .sys_rst, .progStart, .freeMode, .eventMatch, .eventDefined,
    .startSel, .haltSel, .stopEnable, .stopSel, .capturing, .stopped,
    .newestIndex, .bufferWrapped, .timeStamp);

// ===== dv/btac_target_bus.sv
// target bus model presenting random bus cycles
`timescale 1ns/1ps
module btac_target_bus (
    input wire ref_clk,
    input wire active,
    input wire gaps,
    input wire busReady,
    output reg busValid,
    output reg [23:0] busAddr,
    output reg [15:0] busData,
    output reg busWrite,
    output reg [2:0] cycleKind,
    output reg [21:0] misc
);
    integer seed = 32'hBC73A76B;
    initial {busValid, busAddr, busData, busWrite, cycleKind, misc} = '0;
    // fields change every cycle unless busReady low holds a valid cycle, also while idle
    always @(posedge ref_clk) if (!busValid || busReady) begin
        #1;
        busValid = active && (!gaps || $random(seed) % 2);
        busAddr = $random(seed);
        busData = $random(seed);
        busWrite = $random(seed);
        cycleKind = 3'h1 << ($random(seed) & 3);
        misc = $random(seed);
    end
endmodule // btac_target_bus

// ===== dv/testbench.sv
// self-checking bench for the trace capture control
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0, sys_rst = 1'b1, progStart = 1'b0;
    reg active = 1'b0, gaps = 1'b0, mon = 1'b0, freeMode = 1'b1;
    reg stopEnable = 1'b0, delayEnable = 1'b0;
    reg [15:0] eventMatch = 16'h0, eventDefined = 16'hFFFF, startSel = 16'h0;
    reg [15:0] haltSel = 16'h0, stopSel = 16'h0, delaySel = 16'h0;
    reg [15:0] delayCount = 16'h3;
    reg [63:0] rangeStartSel = 64'h0, rangeEndSel = 64'h0;
    reg [3:0] tsResolution = 4'h9, rangeEnable = 4'h0, readIndex = 4'h0;
    reg [2:0] suppressMask = 3'h0;
    wire busValid, busWrite, busReady, capturing, stopped, bufferWrapped;
    wire [23:0] busAddr;
    wire [15:0] busData;
    wire [2:0] cycleKind;
    wire [21:0] misc;
    wire [62:0] readRecord;
    wire [3:0] newestIndex, stopIndex;
    wire [31:0] timeStamp;
    reg [62:0] expq[$];
    integer error_cnt = 0, comparisons = 0, seed = 32'hBC73A76B, i, k, n;
    btac_target_bus btac_target_bus_inst (.ref_clk, .active, .gaps,
        .busReady, .busValid, .busAddr, .busData, .busWrite, .cycleKind,
        .misc);
    btac_trace_ctrl btac_trace_ctrl_inst (.ref_clk, .sys_rst, .progStart,
        .busValid, .busAddr, .busData, .busWrite, .busArea(misc[21:19]),
        .busStatus(misc[18:16]), .busClocks(misc[15:13]),
        .probes(misc[12:9]), .nmiLevel(misc[8]), .irqLevels(misc[7:0]),
        .cycleKind, .eventMatch, .eventDefined, .suppressMask, .tsResolution,
        .freeMode, .startSel, .haltSel, .stopEnable, .stopSel, .delayEnable,
        .delaySel, .delayCount, .rangeStartSel, .rangeEndSel, .rangeEnable,
        .readIndex, .readRecord, .capturing, .stopped, .newestIndex,
        .stopIndex, .bufferWrapped, .timeStamp, .busReady);
    initial forever #5 ref_clk = ~ref_clk;
    // expected records: stamp layout, stamp still zero at 100 us ticks
    always @(posedge ref_clk)
        if (mon && busValid && !(|(cycleKind & suppressMask)))
            expq.push_back({busAddr, busData, busWrite, 1'b1, 16'h0});
    task chk(input [63:0] got, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: got %h expected %h", $time,
                    got, exp);
            end
        end
    endtask
    task step(input integer c);
        begin
            repeat (c) @(posedge ref_clk);
            #1;
        end
    endtask
    task start(input f);
        begin
            freeMode = f;
            progStart = 1'b1;
            step(1);
            progStart = 1'b0;
            active = 1'b1;
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            suppressMask = 3'h1 << i;
            rangeEnable = $random(seed);
            rangeStartSel = {$random(seed), $random(seed)};
            expq.delete();
            mon = 1'b1;
            start(1'b1);
            step(50);
            active = 1'b0;
            step(4);
            mon = 1'b0;
            n = expq.size();
            chk(n > 16, 1);
            chk(newestIndex, 4'((n - 1) % 16));
            chk(bufferWrapped, 1);
            for (k = 0; k < 16; k = k + 1) begin
                readIndex = 4'(n - 1 - k);
                step(1);
                chk(readRecord, expq[n - 1 - k]);
            end
            $display("free capture test done, mask %h", suppressMask);
        end
        tsResolution = 4'h4;
        start(1'b1);
        chk(timeStamp, 0);
        step(1000);
        chk(timeStamp == 32'hA || timeStamp == 32'h9, 1);
        $display("time stamp test done");
        gaps = 1'b1;
        eventDefined = 16'hFFFF;
        startSel = 16'h1;
        haltSel = 16'h2;
        start(1'b0);
        step(10);
        chk(newestIndex, 4'hF);
        chk(capturing, 0);
        eventMatch = 16'h1;
        step(1);
        eventMatch = 16'h2 & {16{1'b0}};
        step(6);
        chk(capturing, 1);
        eventMatch = 16'h2;
        step(1);
        eventMatch = 16'h0;
        step(2);
        chk(stopped, 1);
        chk(capturing, 0);
        $display("start and halt test done");
        startSel = 16'h0;
        haltSel = 16'h0;
        stopEnable = 1'b1;
        stopSel = 16'h8;
        eventDefined = 16'hFFF7;
        start(1'b1);
        step(5);
        eventMatch = 16'h8;
        step(1);
        eventMatch = 16'h0;
        step(2);
        chk(stopped, 0);
        eventDefined = 16'hFFFF;
        eventMatch = 16'h8;
        step(1);
        eventMatch = 16'h0;
        step(2);
        chk(stopped, 1);
        $display("immediate stop test done");
        gaps = 1'b0;
        suppressMask = 3'h0;
        delayEnable = 1'b1;
        delaySel = 16'h4;
        expq.delete();
        start(1'b1);
        mon = 1'b1;
        step(5);
        eventMatch = 16'h4;
        step(1);
        k = expq.size();
        eventMatch = 16'h0;
        step(1);
        chk(stopped, 0);
        step(6);
        chk(stopped, 1);
        chk(stopIndex, 4'((k - 1) % 16));
        mon = 1'b0;
        active = 1'b0;
        $display("delayed stop test done");
        tally_and_finish;
    end
endmodule // testbench
